// ### src/ipi_ctrl.sv
`timescale 1ns/1ps

// Summary of operation
// - First priority register at 0xF6, all pages, resets to zero, bit 7 reserved.
// - First register bits 6..4 set comparator 2, 1, 0 priority; 1 is high.
// - First register bit 3 counter array, bit 2 ADC0 window priority.
// - First register bit 1 SMBus, bit 0 SPI priority; 1 is high.
// - Second priority register at 0xF7, all pages, resets to zero, bit 7 reserved.
// - Second register bit 6 sets UART1 priority.
// - Second register bit 5 sets CAN controller priority.
// - Second register bits 4 and 3 set ADC2 conversion and window priority.
// - Second register bits 2..0 set Timer 4, ADC0 conversion, Timer 3 priority.
// - Stop halts CPU, silences interrupts and timers, stops the oscillator.
// - Once the oscillator is off only a reset restarts operation.
// - Setting the idle bit halts the CPU after the setting instruction completes.
// - Idle keeps registers, memory and peripheral clocks running.
// - Enabled interrupt or reset pin ends idle; interrupt clears idle bit.
// - Interrupt wake services the request, then resumes after the idle-setting instruction.
// - Reset ending idle runs normal reset sequence from address 0x0000.
// - Running watchdog expiring during idle issues internal reset ending idle.
// - Power control bit 0 enters idle, bit 1 enters stop; both read zero.
// - Only a reset ends stop; an enabled missing-clock detector makes one.
// - Interrupt enabled only when global enable and its own mask are both set.
module ipi_ctrl #(
	parameter int NUM_SRC = ipi_pkg::NUM_SRC
) (
	input  wire logic                         mclk,
	input  wire logic                         rst_b,
	input  wire logic [ipi_pkg::SFR_AW-1:0]   sfr_addr,
	input  wire logic                         sfr_wr,
	input  wire logic                         sfr_rd,
	input  wire logic [ipi_pkg::SFR_DW-1:0]   sfr_wdata,
	output logic      [ipi_pkg::SFR_DW-1:0]   sfr_rdata,
	input  wire logic                         instr_done,
	input  wire logic [NUM_SRC-1:0]           irq_req,
	input  wire logic [NUM_SRC-1:0]           irq_mask,
	input  wire logic                         global_irq_enable,
	input  wire logic                         irq_ack,
	input  wire logic                         return_from_interrupt,
	input  wire logic                         watchdog_expire,
	input  wire logic                         mcd_expire,
	output logic                              irq_pend,
	output logic      [ipi_pkg::ID_W-1:0]     irq_id,
	output logic                              irq_high,
	output logic                              svc_high,
	output logic                              svc_low,
	output logic                              cpu_halt,
	output logic                              periph_clk_en,
	output logic                              osc_stop,
	output logic                              idle_mode,
	output logic                              stop_mode,
	output logic                              internal_reset
);

	////////////////////////////////////////////////////////////////////////////////
	// Register access decode

	function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
		hit = (a == target);
	endfunction

	logic                         wr_prio_a;
	logic                         wr_prio_b;
	logic                         wr_pwr;

	assign wr_prio_a = sfr_wr && hit(sfr_addr, ipi_pkg::ADDR_PRIO_A);
	assign wr_prio_b = sfr_wr && hit(sfr_addr, ipi_pkg::ADDR_PRIO_B);
	assign wr_pwr    = sfr_wr && hit(sfr_addr, ipi_pkg::ADDR_PWR);

	////////////////////////////////////////////////////////////////////////////////
	// Priority registers

	logic [7:0]                   prio_a_r;
	logic [7:0]                   prio_a_nxt;
	logic [7:0]                   prio_b_r;
	logic [7:0]                   prio_b_nxt;
	logic [7:0]                   rdata_r;
	logic [7:0]                   rdata_nxt;

	always_comb begin
		prio_a_nxt = prio_a_r;
		prio_b_nxt = prio_b_r;
		if (wr_prio_a) begin
			prio_a_nxt = sfr_wdata & ipi_pkg::PRIO_WMASK;
		end
		if (wr_prio_b) begin
			prio_b_nxt = sfr_wdata & ipi_pkg::PRIO_WMASK;
		end
	end

	// Read data registered; power control always reads zero
	always_comb begin
		rdata_nxt = rdata_r;
		if (sfr_rd) begin
			if (hit(sfr_addr, ipi_pkg::ADDR_PRIO_A)) begin
				rdata_nxt = prio_a_r;
			end else if (hit(sfr_addr, ipi_pkg::ADDR_PRIO_B)) begin
				rdata_nxt = prio_b_r;
			end else if (hit(sfr_addr, ipi_pkg::ADDR_PWR)) begin
				rdata_nxt = ipi_pkg::PWR_READ;
			end else begin
				rdata_nxt = 8'h00;
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			prio_a_r <= ipi_pkg::PRIO_A_RST;
			prio_b_r <= ipi_pkg::PRIO_B_RST;
			rdata_r  <= 8'h00;
		end else begin
			prio_a_r <= prio_a_nxt;
			prio_b_r <= prio_b_nxt;
			rdata_r  <= rdata_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Per-source priority level

	logic                         cmp2_priority;
	logic                         cmp1_priority;
	logic                         cmp0_priority;
	logic                         counter_array_priority;
	logic                         adc0_window_priority;
	logic                         smbus_priority;
	logic                         spi_priority;
	logic                         uart1_priority;
	logic                         can_priority;
	logic                         adc2_eoc_priority;
	logic                         adc2_window_priority;
	logic                         timer4_priority;
	logic                         adc0_eoc_priority;
	logic                         timer3_priority;
	logic [NUM_SRC-1:0]           src_high;

	assign cmp2_priority          = prio_a_r[ipi_pkg::POS_CMP2];
	assign cmp1_priority          = prio_a_r[ipi_pkg::POS_CMP1];
	assign cmp0_priority          = prio_a_r[ipi_pkg::POS_CMP0];
	assign counter_array_priority = prio_a_r[ipi_pkg::POS_CNT_ARR];
	assign adc0_window_priority   = prio_a_r[ipi_pkg::POS_ADC0_WIN];
	assign smbus_priority         = prio_a_r[ipi_pkg::POS_SMBUS];
	assign spi_priority           = prio_a_r[ipi_pkg::POS_SPI];
	assign uart1_priority         = prio_b_r[ipi_pkg::POS_UART1];
	assign can_priority           = prio_b_r[ipi_pkg::POS_CAN];
	assign adc2_eoc_priority      = prio_b_r[ipi_pkg::POS_ADC2_EOC];
	assign adc2_window_priority   = prio_b_r[ipi_pkg::POS_ADC2_WIN];
	assign timer4_priority        = prio_b_r[ipi_pkg::POS_TIMER4];
	assign adc0_eoc_priority      = prio_b_r[ipi_pkg::POS_ADC0_EOC];
	assign timer3_priority        = prio_b_r[ipi_pkg::POS_TIMER3];

	// Source index = field position, second register sources follow at +7
	assign src_high = {
		uart1_priority, can_priority, adc2_eoc_priority, adc2_window_priority,
		timer4_priority, adc0_eoc_priority, timer3_priority,
		cmp2_priority, cmp1_priority, cmp0_priority, counter_array_priority,
		adc0_window_priority, smbus_priority, spi_priority
	};

	////////////////////////////////////////////////////////////////////////////////
	// Request qualification and selection

	logic [NUM_SRC-1:0]           enabled_req;
	logic [NUM_SRC-1:0]           hi_req;
	logic [NUM_SRC-1:0]           lo_req;
	logic                         any_enabled;
	logic                         hi_found;
	logic                         lo_found;
	logic [ipi_pkg::ID_W-1:0]     hi_idx;
	logic [ipi_pkg::ID_W-1:0]     lo_idx;

	assign enabled_req = irq_req & irq_mask & {NUM_SRC{global_irq_enable}};
	assign any_enabled = |enabled_req;
	assign hi_req      = enabled_req & src_high;
	assign lo_req      = enabled_req & ~src_high;

	ipi_pick #(
		.N  (NUM_SRC),
		.IW (ipi_pkg::ID_W)
	) u_pick_hi (
		.req   (hi_req),
		.found (hi_found),
		.idx   (hi_idx)
	);

	ipi_pick #(
		.N  (NUM_SRC),
		.IW (ipi_pkg::ID_W)
	) u_pick_lo (
		.req   (lo_req),
		.found (lo_found),
		.idx   (lo_idx)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Power mode sequencing

	ipi_pkg::ipi_mode_t           mode_r;
	ipi_pkg::ipi_mode_t           mode_nxt;
	logic                         idle_arm_r;
	logic                         idle_arm_nxt;
	logic                         stop_arm_r;
	logic                         stop_arm_nxt;
	logic                         ireset_r;
	logic                         ireset_nxt;

	always_comb begin
		mode_nxt     = mode_r;
		idle_arm_nxt = idle_arm_r | (wr_pwr & sfr_wdata[ipi_pkg::POS_IDLE]);
		stop_arm_nxt = stop_arm_r | (wr_pwr & sfr_wdata[ipi_pkg::POS_STOP]);
		ireset_nxt   = 1'b0;
		unique case (mode_r)
			ipi_pkg::IPI_RUN: begin
				// Entry waits for the setting instruction to finish
				if (instr_done && stop_arm_nxt) begin
					mode_nxt = ipi_pkg::IPI_STOP;
				end else if (instr_done && idle_arm_nxt) begin
					mode_nxt = ipi_pkg::IPI_IDLE;
				end
				if (instr_done) begin
					idle_arm_nxt = 1'b0;
					stop_arm_nxt = 1'b0;
				end
			end
			ipi_pkg::IPI_IDLE: begin
				idle_arm_nxt = 1'b0;
				stop_arm_nxt = 1'b0;
				if (any_enabled) begin
					mode_nxt = ipi_pkg::IPI_RUN;
				end
			end
			ipi_pkg::IPI_STOP: begin
				// Only the reset returning on rst_b leaves this state
				idle_arm_nxt = 1'b0;
				stop_arm_nxt = 1'b0;
			end
		endcase
		// Watchdog runs in run and idle; detector acts in any mode
		if (watchdog_expire && mode_r != ipi_pkg::IPI_STOP) begin
			ireset_nxt = 1'b1;
		end
		if (mcd_expire) begin
			ireset_nxt = 1'b1;
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			mode_r     <= ipi_pkg::IPI_RUN;
			idle_arm_r <= 1'b0;
			stop_arm_r <= 1'b0;
			ireset_r   <= 1'b0;
		end else begin
			mode_r     <= mode_nxt;
			idle_arm_r <= idle_arm_nxt;
			stop_arm_r <= stop_arm_nxt;
			ireset_r   <= ireset_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Two-level service tracking and request presentation

	logic                         svc_hi_r;
	logic                         svc_hi_nxt;
	logic                         svc_lo_r;
	logic                         svc_lo_nxt;
	logic                         pend_r;
	logic                         pend_nxt;
	logic [ipi_pkg::ID_W-1:0]     id_r;
	logic [ipi_pkg::ID_W-1:0]     id_nxt;
	logic                         high_r;
	logic                         high_nxt;

	always_comb begin
		svc_hi_nxt = svc_hi_r;
		svc_lo_nxt = svc_lo_r;
		// Return ends the innermost service, high before low
		if (return_from_interrupt) begin
			if (svc_hi_r) begin
				svc_hi_nxt = 1'b0;
			end else begin
				svc_lo_nxt = 1'b0;
			end
		end
		if (irq_ack && pend_r) begin
			if (high_r) begin
				svc_hi_nxt = 1'b1;
			end else begin
				svc_lo_nxt = 1'b1;
			end
		end
	end

	always_comb begin
		pend_nxt = 1'b0;
		id_nxt   = id_r;
		high_nxt = high_r;
		// Stop silences every request; an ack withdraws until service updates
		if (mode_nxt != ipi_pkg::IPI_STOP && !irq_ack) begin
			if (hi_found && !svc_hi_nxt) begin
				pend_nxt = 1'b1;
				id_nxt   = hi_idx;
				high_nxt = 1'b1;
			end else if (lo_found && !svc_hi_nxt && !svc_lo_nxt) begin
				pend_nxt = 1'b1;
				id_nxt   = lo_idx;
				high_nxt = 1'b0;
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			svc_hi_r <= 1'b0;
			svc_lo_r <= 1'b0;
			pend_r   <= 1'b0;
			id_r     <= '0;
			high_r   <= 1'b0;
		end else begin
			svc_hi_r <= svc_hi_nxt;
			svc_lo_r <= svc_lo_nxt;
			pend_r   <= pend_nxt;
			id_r     <= id_nxt;
			high_r   <= high_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Registered mode outputs

	logic                         halt_r;
	logic                         pclk_r;
	logic                         osc_r;
	logic                         idle_r;
	logic                         stop_r;
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			halt_r <= 1'b0;
			pclk_r <= 1'b1;
			osc_r  <= 1'b0;
			idle_r <= 1'b0;
			stop_r <= 1'b0;
		end else begin
			halt_r <= (mode_nxt != ipi_pkg::IPI_RUN);
			pclk_r <= (mode_nxt != ipi_pkg::IPI_STOP);
			osc_r  <= (mode_nxt == ipi_pkg::IPI_STOP);
			idle_r <= (mode_nxt == ipi_pkg::IPI_IDLE);
			stop_r <= (mode_nxt == ipi_pkg::IPI_STOP);
		end
	end

	assign sfr_rdata      = rdata_r;
	assign irq_pend       = pend_r;
	assign irq_id         = id_r;
	assign irq_high       = high_r;
	assign svc_high       = svc_hi_r;
	assign svc_low        = svc_lo_r;
	assign cpu_halt       = halt_r;
	assign periph_clk_en  = pclk_r;
	assign osc_stop       = osc_r;
	assign idle_mode      = idle_r;
	assign stop_mode      = stop_r;
	assign internal_reset = ireset_r;

endmodule

// ### shared/ipi_pkg.sv
package ipi_pkg;

	// Source count and widths
	localparam int          NUM_SRC     = 14;
	localparam int          ID_W        = 4;
	localparam int          SFR_AW      = 8;
	localparam int          SFR_DW      = 8;

	// Special-function addresses, visible from every page
	localparam logic [7:0]  ADDR_PRIO_A = 8'hF6;
	localparam logic [7:0]  ADDR_PRIO_B = 8'hF7;
	localparam logic [7:0]  ADDR_PWR    = 8'h87;

	// Reset values
	localparam logic [7:0]  PRIO_A_RST  = 8'h00;
	localparam logic [7:0]  PRIO_B_RST  = 8'h00;
	localparam logic [7:0]  PWR_READ    = 8'h00;

	// Writable field mask, bit 7 reserved in both priority registers
	localparam logic [7:0]  PRIO_WMASK  = 8'h7F;
	localparam int          PRIO_FIELDS = 7;

	// First priority register fields
	localparam int          POS_SPI     = 0;
	localparam int          POS_SMBUS   = 1;
	localparam int          POS_ADC0_WIN = 2;
	localparam int          POS_CNT_ARR = 3;
	localparam int          POS_CMP0    = 4;
	localparam int          POS_CMP1    = 5;
	localparam int          POS_CMP2    = 6;

	// Second priority register fields
	localparam int          POS_TIMER3  = 0;
	localparam int          POS_ADC0_EOC = 1;
	localparam int          POS_TIMER4  = 2;
	localparam int          POS_ADC2_WIN = 3;
	localparam int          POS_ADC2_EOC = 4;
	localparam int          POS_CAN     = 5;
	localparam int          POS_UART1   = 6;

	// Power control fields
	localparam int          POS_IDLE    = 0;
	localparam int          POS_STOP    = 1;

	// Restart address after any reset
	localparam logic [15:0] RESET_VECTOR = 16'h0000;

	// Power modes
	typedef enum logic [1:0] {
		IPI_RUN,
		IPI_IDLE,
		IPI_STOP
	} ipi_mode_t;

endpackage

// ### src/ipi_pick.sv
`timescale 1ns/1ps

// Lowest-index set request wins
module ipi_pick #(
	parameter int N  = 14,
	parameter int IW = 4
) (
	input  wire logic [N-1:0]  req,
	output logic               found,
	output logic [IW-1:0]      idx
);

	always_comb begin
		found = 1'b0;
		idx   = '0;
		for (int i = N - 1; i >= 0; i--) begin
			if (req[i]) begin
				found = 1'b1;
				idx   = IW'(i);
			end
		end
	end

endmodule

// ### testbench/ipi_assertions.sv
`timescale 1ns/1ps

module ipi_assertions #(
	parameter int NUM_SRC = ipi_pkg::NUM_SRC
) (
	input	wire logic			mclk,
	input	wire logic			rst_b,
	input	wire logic	[7:0]		sfr_addr,
	input	wire logic			sfr_wr,
	input	wire logic	[7:0]		sfr_wdata,
	input	wire logic			instr_done,
	input	wire logic	[NUM_SRC-1:0]	irq_req,
	input	wire logic	[NUM_SRC-1:0]	irq_mask,
	input	wire logic			global_irq_enable,
	input	wire logic			irq_ack,
	input	wire logic			watchdog_expire,
	input	wire logic			mcd_expire,
	input	wire logic			irq_pend,
	input	wire logic			irq_high,
	input	wire logic			svc_high,
	input	wire logic			cpu_halt,
	input	wire logic			periph_clk_en,
	input	wire logic			osc_stop,
	input	wire logic			idle_mode,
	input	wire logic			stop_mode,
	input	wire logic			internal_reset
);
	logic	wake;
	logic	idle_wr;

	assign wake = global_irq_enable && |(irq_req & irq_mask);
	assign idle_wr = sfr_wr && sfr_addr == ipi_pkg::ADDR_PWR && sfr_wdata[1:0] == 2'b01;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b);

	////////////////////////////////////////////////////////////////////////////
	pend_gate_a: assert property (irq_pend |-> $past(wake))
		else $error("request shown while not enabled");
	ack_svc_a: assert property (irq_ack && irq_pend |=> svc_high || !$past(irq_high))
		else $error("high request taken without high service");
	idle_entry_a: assert property (idle_wr && instr_done && !stop_mode |=> idle_mode && cpu_halt)
		else $error("idle not entered");
	idle_keep_a: assert property (idle_mode |-> cpu_halt && periph_clk_en && !osc_stop)
		else $error("idle outputs wrong");
	idle_wake_a: assert property (idle_mode && wake |=> !idle_mode && !cpu_halt)
		else $error("idle not left on request");
	stop_quiet_a: assert property (stop_mode |-> cpu_halt && osc_stop && !periph_clk_en && !irq_pend)
		else $error("stop outputs wrong");
	stop_hold_a: assert property (stop_mode |=> stop_mode)
		else $error("stop left without reset");
	wdt_reset_a: assert property (watchdog_expire && !stop_mode |=> internal_reset)
		else $error("watchdog reset missing");
	mcd_reset_a: assert property (mcd_expire |=> internal_reset)
		else $error("clock detector reset missing");
endmodule

bind ipi_ctrl ipi_assertions #(.NUM_SRC(NUM_SRC)) i_ipi_assertions (
	.mclk(mclk), .rst_b(rst_b), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
	.sfr_wdata(sfr_wdata), .instr_done(instr_done), .irq_req(irq_req),
	.irq_mask(irq_mask), .global_irq_enable(global_irq_enable), .irq_ack(irq_ack),
	.watchdog_expire(watchdog_expire), .mcd_expire(mcd_expire), .irq_pend(irq_pend),
	.irq_high(irq_high), .svc_high(svc_high), .cpu_halt(cpu_halt),
	.periph_clk_en(periph_clk_en), .osc_stop(osc_stop), .idle_mode(idle_mode),
	.stop_mode(stop_mode), .internal_reset(internal_reset)
);

// ### testbench/ipi_core_model.sv
`timescale 1ns/1ps

module ipi_core_model #(
	parameter int SVC_LEN = 12
) (
	input	wire logic	mclk,
	input	wire logic	rst_b,
	input	wire logic	auto_en,
	input	wire logic	irq_pend,
	output	logic		irq_ack,
	output	logic		return_from_interrupt
);
	int	depth;
	int	cnt;

	// Take a shown request, return after a fixed service time
	always @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			irq_ack <= 1'b0;
			return_from_interrupt <= 1'b0;
			depth <= 0;
			cnt <= 0;
		end else begin
			irq_ack <= auto_en && irq_pend && !irq_ack;
			return_from_interrupt <= 1'b0;
			if (irq_ack) begin
				depth <= depth + 1;
				cnt <= SVC_LEN;
			end else if (depth > 0 && cnt == 0) begin
				return_from_interrupt <= 1'b1;
				depth <= depth - 1;
				cnt <= SVC_LEN;
			end else if (cnt > 0) begin
				cnt <= cnt - 1;
			end
		end
	end
endmodule

// ### testbench/tb.sv
`timescale 1ns/1ps

module tb;
	logic		mclk, rst_b, sfr_wr, sfr_rd, instr_done, global_irq_enable, auto_en;
	logic		irq_ack, return_from_interrupt, watchdog_expire, mcd_expire, irq_pend;
	logic		irq_high, svc_high, svc_low, cpu_halt, periph_clk_en, osc_stop;
	logic		idle_mode, stop_mode, internal_reset;
	logic	[7:0]	sfr_addr, sfr_wdata, sfr_rdata;
	logic	[13:0]	irq_req, irq_mask;
	logic	[3:0]	irq_id;
	int		n_fail, n_tests;

	ipi_ctrl i_ipi_ctrl (
		.mclk(mclk), .rst_b(rst_b), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
		.sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
		.instr_done(instr_done), .irq_req(irq_req), .irq_mask(irq_mask),
		.global_irq_enable(global_irq_enable), .irq_ack(irq_ack),
		.return_from_interrupt(return_from_interrupt), .watchdog_expire(watchdog_expire),
		.mcd_expire(mcd_expire), .irq_pend(irq_pend), .irq_id(irq_id),
		.irq_high(irq_high), .svc_high(svc_high), .svc_low(svc_low),
		.cpu_halt(cpu_halt), .periph_clk_en(periph_clk_en), .osc_stop(osc_stop),
		.idle_mode(idle_mode), .stop_mode(stop_mode), .internal_reset(internal_reset)
	);

	ipi_core_model i_ipi_core_model (
		.mclk(mclk), .rst_b(rst_b), .auto_en(auto_en), .irq_pend(irq_pend),
		.irq_ack(irq_ack), .return_from_interrupt(return_from_interrupt)
	);

	////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED at %0t: %s", $time, m);
		end
	endtask

	task automatic stop_test();
		if (n_fail == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		{sfr_addr, sfr_wdata, sfr_wr} <= {a, d, 1'b1};
		@(posedge mclk);
		sfr_wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge mclk);
		{sfr_addr, sfr_rd} <= {a, 1'b1};
		@(posedge mclk);
		sfr_rd <= 1'b0;
		@(negedge mclk);
		chk(sfr_rdata, exp, "read data");
	endtask

	task automatic enter_pm(input logic [7:0] d);
		@(posedge mclk);
		{sfr_addr, sfr_wdata, sfr_wr, instr_done} <= {8'h87, d, 2'b11};
		@(posedge mclk);
		{sfr_wr, instr_done} <= 2'b00; // Instruction ends in the same cycle as the write
		cyc(1);
	endtask

	task automatic pulse(input bit m);
		@(posedge mclk);
		{mcd_expire, watchdog_expire} <= {m, !m};
		@(posedge mclk);
		{mcd_expire, watchdog_expire} <= 2'b00;
		@(negedge mclk);
	endtask

	task automatic do_reset();
		@(posedge mclk);
		rst_b <= 1'b0;
		cyc(2);
		rst_b <= 1'b1;
		@(negedge mclk);
	endtask

	////////////////////////////////////////////////////////////////////////////
	task automatic t_regs();
		rd(8'hF6, 8'h00);
		rd(8'hF7, 8'h00);
		wr(8'hF6, 8'hFF);
		wr(8'hF7, 8'hFF);
		rd(8'hF6, 8'h7F);
		rd(8'hF7, 8'h7F);
		rd(8'h87, 8'h00);
		rd(8'h55, 8'h00);
		wr(8'hF6, 8'h00);
		wr(8'hF7, 8'h00);
	endtask

	task automatic t_prio();
		logic [7:0] a;
		{irq_mask, global_irq_enable} <= {14'h3FFF, 1'b1};
		for (int i = 0; i < 14; i++) begin
			a = (i < 7) ? 8'hF6 : 8'hF7;
			wr(a, 8'h01 << (i % 7));
			irq_req <= 14'h0001 << i;
			cyc(3);
			@(negedge mclk);
			chk({irq_pend, irq_id, irq_high}, {1'b1, 4'(i), 1'b1}, "high");
			wr(a, 8'h00);
			cyc(3);
			@(negedge mclk);
			chk({irq_pend, irq_id, irq_high}, {1'b1, 4'(i), 1'b0}, "low");
			@(posedge mclk);
			irq_req <= '0;
		end
	endtask

	task automatic t_gate();
		@(posedge mclk);
		{irq_req, irq_mask, global_irq_enable} <= {14'h0010, 14'h0000, 1'b1};
		cyc(3);
		@(negedge mclk);
		chk(irq_pend, 1'b0, "masked");
		@(posedge mclk);
		{irq_mask, global_irq_enable} <= {14'h3FFF, 1'b0};
		cyc(3);
		@(negedge mclk);
		chk(irq_pend, 1'b0, "global off");
		@(posedge mclk);
		global_irq_enable <= 1'b1;
		cyc(3);
		@(negedge mclk);
		chk({irq_pend, irq_id}, 5'h14, "enabled");
		@(posedge mclk);
		irq_req <= '0;
	endtask

	task automatic t_preempt();
		wr(8'hF6, 8'h01);
		{auto_en, irq_req} <= {1'b1, 14'h0020};
		for (int k = 0; k < 30 && svc_low !== 1'b1; k++) @(negedge mclk);
		@(posedge mclk);
		irq_req <= 14'h0004;
		cyc(3);
		@(negedge mclk);
		chk({irq_pend, svc_low}, 2'b01, "low on low");
		@(posedge mclk);
		irq_req <= 14'h0005;
		for (int k = 0; k < 30 && svc_high !== 1'b1; k++) @(negedge mclk);
		@(negedge mclk);
		chk({svc_high, svc_low, irq_pend}, 3'b110, "preempt");
		@(posedge mclk);
		irq_req <= '0;
		for (int k = 0; k < 80 && svc_low !== 1'b0; k++) @(negedge mclk);
		chk({svc_high, svc_low, irq_pend}, 3'b000, "returns");
		@(posedge mclk);
		auto_en <= 1'b0;
		wr(8'hF6, 8'h00);
	endtask

	task automatic t_idle();
		wr(8'hF7, 8'h2A);
		enter_pm(8'h01);
		cyc(4); // Watchdog left quiet
		@(negedge mclk);
		chk({idle_mode, cpu_halt, periph_clk_en, osc_stop}, 4'b1110, "idle");
		@(posedge mclk);
		irq_req <= 14'h0080;
		cyc(2);
		@(negedge mclk);
		chk({idle_mode, cpu_halt, irq_pend}, 3'b001, "wake");
		@(posedge mclk);
		auto_en <= 1'b1;
		for (int k = 0; k < 30 && svc_low !== 1'b1; k++) @(negedge mclk);
		@(posedge mclk);
		irq_req <= '0;
		for (int k = 0; k < 40 && svc_low !== 1'b0; k++) @(negedge mclk);
		chk({svc_low, idle_mode}, 2'b00, "serviced");
		@(posedge mclk);
		auto_en <= 1'b0;
		rd(8'h87, 8'h00);
		rd(8'hF7, 8'h2A);
		enter_pm(8'h01);
		pulse(1'b0);
		chk({internal_reset, idle_mode}, 2'b11, "watchdog");
		do_reset();
		chk({idle_mode, cpu_halt}, 2'b00, "reset ends idle");
		rd(8'hF7, 8'h00);
	endtask

	task automatic t_stop();
		enter_pm(8'h02);
		@(negedge mclk);
		chk({stop_mode, cpu_halt, periph_clk_en, osc_stop}, 4'b1101, "stop");
		@(posedge mclk);
		irq_req <= 14'h0001;
		cyc(3);
		pulse(1'b0);
		chk({irq_pend, internal_reset, stop_mode}, 3'b001, "stop quiet");
		pulse(1'b1);
		chk({internal_reset, stop_mode}, 2'b11, "clock detector");
		do_reset();
		chk({stop_mode, osc_stop, periph_clk_en}, 3'b001, "reset ends stop");
		@(posedge mclk);
		irq_req <= '0;
	endtask

	////////////////////////////////////////////////////////////////////////////
	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end

	initial begin
		#200000;
		n_fail++;
		stop_test();
	end

	initial begin
		{rst_b, sfr_wr, sfr_rd, instr_done, global_irq_enable} = '0;
		{watchdog_expire, mcd_expire, auto_en} = '0;
		{sfr_addr, sfr_wdata, irq_req, irq_mask} = '0;
		n_fail = 0;
		n_tests = 0;
		cyc(2);
		rst_b <= 1'b1;
		t_regs();
		t_prio();
		t_gate();
		t_preempt();
		t_idle();
		t_stop();
		stop_test();
	end
endmodule
